// ---- ascd_pkg.sv ----
/*
  Package for the serial command decoder: opcodes, register map,
  reset values and timing counts shared by both ends.
  Assumes one 40 MHz system clock for both ends.
*/
package ascd_pkg;
  // Opcodes
  localparam logic [7:0] OP_READ_RESULT   = 8'h01;
  localparam logic [7:0] OP_READ_CONT     = 8'h03;
  localparam logic [7:0] OP_STOP_CONT     = 8'h0F;
  localparam logic [3:0] OP_REGISTER_READ_CMD_HI       = 4'h1;
  localparam logic [3:0] OP_REGISTER_WRITE_CMD_HI       = 4'h5;
  localparam logic [7:0] OP_CAL_FULL      = 8'hF0;
  localparam logic [7:0] OP_CAL_OFFSET    = 8'hF1;
  localparam logic [7:0] OP_CAL_GAIN      = 8'hF2;
  localparam logic [7:0] OP_SYS_OFFSET    = 8'hF3;
  localparam logic [7:0] OP_SYS_GAIN      = 8'hF4;
  localparam logic [7:0] OP_WAKE          = 8'hFB;
  localparam logic [7:0] OP_RESYNC        = 8'hFC;
  localparam logic [7:0] OP_SLEEP         = 8'hFD;
  localparam logic [7:0] OP_RESET         = 8'hFE;
  // Register map
  localparam int          REG_COUNT       = 16;
  localparam logic [3:0]  ADDR_STATUS     = 4'h2;
  localparam int          STATUS_RDY_BIT  = 7;
  localparam logic [3:0]  ADDR_OCR0       = 4'h7;
  localparam logic [3:0]  ADDR_FSR0       = 4'hA;
  localparam logic [3:0]  ADDR_RESULT_MSB = 4'hD;
  localparam logic [3:0]  ADDR_FIRST_RO   = 4'hD;
  // Reset values, low byte at index 0
  localparam logic [127:0] REG_RESET_VAL  =
    {8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h59, 8'h00, 8'h00,
     8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
  // Timing: host waits 10 oscillator periods after ready falls
  localparam int          OSC_WAIT_PERIODS = 10;
  localparam int          SCLK_DIV         = 4;
  localparam int          CONV_CYCLES_DEF  = 4000;
  localparam int          CAL_CYCLES_DEF   = 400;
endpackage

// ---- ascd_if.sv ----
/*
  Serial link between the decoder (device end) and the host end.
  Assumes the host makes the serial clock as an enable-gated strobe.
*/
`timescale 1ns/10ps
`default_nettype none
interface ascd_if;
  logic sclk;       // Serial clock level from host
  logic sclk_rise;  // One-cycle pulse: host sample edge
  logic cs_n;       // Chip select, active low
  logic din;        // Host to device data
  logic dout;       // Device to host data
  logic ready_n;    // Result ready, active low
  modport dev  (input sclk, sclk_rise, cs_n, din, output dout, ready_n);
  modport host (output sclk, sclk_rise, cs_n, din, input dout, ready_n);
endinterface
`default_nettype wire

// ---- ascd_device.sv ----
/*
  Device end: serial command decoder with register file, result
  readout, continuous read, calibrations, sleep and resync.
  Assumes host bytes arrive MSB first on sclk_rise pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module ascd_device
  import ascd_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter int CAL_CYCLES  = CAL_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  // Serial link
  ascd_if.dev              link,
  // Converter side
  input  wire logic [23:0] sample_in,       // Filter output word
  input  wire logic [23:0] cal_offset_in,   // Computed offset coefficient
  input  wire logic [23:0] cal_gain_in,     // Computed gain coefficient
  output logic             low_power_out,   // Sleep state
  output logic             cal_busy_out     // Calibration running
);
  typedef enum {ST_CMD, ST_COUNT, ST_WDATA, ST_TX} ascd_state_e;

  ascd_state_e       st_r, st_nxt;               // Command state
  logic [7:0]        regs_r   [REG_COUNT];       // Register file
  logic [7:0]        regs_nxt [REG_COUNT];
  logic [7:0]        rx_r, rx_nxt;               // Receive shift
  logic [2:0]        bit_r, bit_nxt;             // Bit counter
  logic [7:0]        tx_r, tx_nxt;               // Transmit shift
  logic [3:0]        addr_r, addr_nxt;           // Register pointer
  logic [3:0]        cnt_r, cnt_nxt;             // Bytes remaining minus one
  logic              is_wr_r, is_wr_nxt;         // Write command pending
  logic              cont_r, cont_nxt;           // Continuous mode
  logic              sleep_r, sleep_nxt;         // Low-power state
  logic [1:0]        cal_r, cal_nxt;             // Bit0 offset, bit1 gain
  logic [15:0]       cal_cnt_r, cal_cnt_nxt;     // Calibration timer
  logic [15:0]       conv_cnt_r, conv_cnt_nxt;   // Conversion timer
  logic              rdy_n_r, rdy_n_nxt;         // Ready pin level
  logic              byte_done;                  // Full byte received
  logic [7:0]        rx_byte;                    // Byte just completed
  logic              conv_tick;                  // Result lands this cycle

  assign byte_done = link.sclk_rise && !link.cs_n && (bit_r == 3'd7);
  assign rx_byte   = {rx_r[6:0], link.din};
  assign conv_tick = !sleep_r && (cal_r == 2'b00) && (conv_cnt_r == 16'(CONV_CYCLES - 1));

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < REG_COUNT; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    rx_nxt = rx_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    cnt_nxt = cnt_r;
    is_wr_nxt = is_wr_r;
    cont_nxt = cont_r;
    sleep_nxt = sleep_r;
    cal_nxt = cal_r;
    cal_cnt_nxt = cal_cnt_r;
    conv_cnt_nxt = conv_cnt_r;
    rdy_n_nxt = rdy_n_r;
    // Conversion timing, paused in sleep and calibration
    if (!sleep_r && cal_r == 2'b00) begin
      if (conv_cnt_r == 16'(CONV_CYCLES - 1)) begin
        conv_cnt_nxt = '0;
        regs_nxt[ADDR_RESULT_MSB]      = sample_in[23:16];
        regs_nxt[ADDR_RESULT_MSB + 4'h1] = sample_in[15:8];
        regs_nxt[ADDR_RESULT_MSB + 4'h2] = sample_in[7:0];
        rdy_n_nxt = 1'b0;
      end else begin
        conv_cnt_nxt = conv_cnt_r + 16'h0001;
      end
    end
    // Calibration completion
    if (cal_r != 2'b00) begin
      if (cal_cnt_r == 16'(CAL_CYCLES - 1)) begin
        if (cal_r[0]) begin
          regs_nxt[ADDR_OCR0]        = cal_offset_in[7:0];
          regs_nxt[ADDR_OCR0 + 4'h1] = cal_offset_in[15:8];
          regs_nxt[ADDR_OCR0 + 4'h2] = cal_offset_in[23:16];
        end
        if (cal_r[1]) begin
          regs_nxt[ADDR_FSR0]        = cal_gain_in[7:0];
          regs_nxt[ADDR_FSR0 + 4'h1] = cal_gain_in[15:8];
          regs_nxt[ADDR_FSR0 + 4'h2] = cal_gain_in[23:16];
        end
        cal_nxt = 2'b00;
        rdy_n_nxt = 1'b0;
      end else begin
        cal_cnt_nxt = cal_cnt_r + 16'h0001;
      end
    end
    // Continuous mode: load result while ready is low, between bytes in command state
    if (cont_r && !rdy_n_r && st_r == ST_CMD && bit_r == 3'd0) begin
      st_nxt = ST_TX;
      addr_nxt = ADDR_RESULT_MSB;
      cnt_nxt = 4'h2;
      tx_nxt = regs_r[ADDR_RESULT_MSB];
      rdy_n_nxt = !conv_tick;  // A fresh result keeps ready low
    end
    // Serial bit handling, MSB first both ways
    if (link.cs_n) begin
      bit_nxt = '0;
    end else if (link.sclk_rise) begin
      rx_nxt = rx_byte;
      bit_nxt = bit_r + 3'd1;
      if (st_r == ST_TX) begin
        tx_nxt = {tx_r[6:0], 1'b0};
      end
    end
    // Byte complete
    if (byte_done) begin
      case (st_r)
        ST_CMD: begin
          if (sleep_r) begin
            if (rx_byte == OP_WAKE) begin
              sleep_nxt = 1'b0;
            end
          end else if (rx_byte == OP_READ_RESULT) begin
            st_nxt = ST_TX;
            addr_nxt = ADDR_RESULT_MSB;
            cnt_nxt = 4'h2;
            tx_nxt = regs_r[ADDR_RESULT_MSB];
            rdy_n_nxt = !conv_tick;  // A fresh result keeps ready low
          end else if (rx_byte == OP_READ_CONT) begin
            cont_nxt = 1'b1;
          end else if (rx_byte == OP_STOP_CONT) begin
            cont_nxt = 1'b0;
          end else if (rx_byte[7:4] == OP_REGISTER_READ_CMD_HI || rx_byte[7:4] == OP_REGISTER_WRITE_CMD_HI) begin
            st_nxt = ST_COUNT;
            addr_nxt = rx_byte[3:0];
            is_wr_nxt = (rx_byte[7:4] == OP_REGISTER_WRITE_CMD_HI);
          end else if (rx_byte >= OP_CAL_FULL && rx_byte <= OP_SYS_GAIN) begin
            case (rx_byte)
              OP_CAL_FULL: cal_nxt = 2'b11;
              OP_CAL_OFFSET, OP_SYS_OFFSET: cal_nxt = 2'b01;
              default: cal_nxt = 2'b10;
            endcase
            cal_cnt_nxt = '0;
            rdy_n_nxt = 1'b1;
          end else if (rx_byte == OP_RESYNC) begin
            conv_cnt_nxt = '0;
            rdy_n_nxt = 1'b1;
          end else if (rx_byte == OP_SLEEP) begin
            sleep_nxt = 1'b1;
          end else if (rx_byte == OP_RESET) begin
            for (int i = 0; i < REG_COUNT; i++) begin
              regs_nxt[i] = REG_RESET_VAL[i*8 +: 8];
            end
            cont_nxt = 1'b0;
          end
          // Anything else ignored
        end
        ST_COUNT: begin
          cnt_nxt = rx_byte[3:0];
          if (is_wr_r) begin
            st_nxt = ST_WDATA;
          end else begin
            st_nxt = ST_TX;
            tx_nxt = regs_r[addr_r];
          end
        end
        ST_WDATA: begin
          if (addr_r < ADDR_FIRST_RO && addr_r != ADDR_STATUS) begin
            regs_nxt[addr_r] = rx_byte;
          end
          addr_nxt = addr_r + 4'h1;
          cnt_nxt = cnt_r - 4'h1;
          if (cnt_r == 4'h0) begin
            st_nxt = ST_CMD;
          end
        end
        ST_TX: begin
          addr_nxt = addr_r + 4'h1;
          cnt_nxt = cnt_r - 4'h1;
          tx_nxt = regs_r[addr_r + 4'h1];
          if (cnt_r == 4'h0) begin
            st_nxt = ST_CMD;
          end
          if (cont_r && (rx_byte == OP_STOP_CONT || rx_byte == OP_RESET)) begin
            cont_nxt = 1'b0;
            if (rx_byte == OP_RESET) begin
              for (int i = 0; i < REG_COUNT; i++) begin
                regs_nxt[i] = REG_RESET_VAL[i*8 +: 8];
              end
            end
          end
        end
        default: st_nxt = ST_CMD;
      endcase
    end
    // Status bit mirrors ready pin
    regs_nxt[ADDR_STATUS][STATUS_RDY_BIT] = rdy_n_nxt;
  end

  // State registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_r <= ST_CMD;
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_r[i] <= REG_RESET_VAL[i*8 +: 8];
      end
      regs_r[ADDR_STATUS][STATUS_RDY_BIT] <= 1'b1;
      rx_r <= 8'h00;
      bit_r <= 3'h0;
      tx_r <= 8'h00;
      addr_r <= 4'h0;
      cnt_r <= 4'h0;
      is_wr_r <= 1'b0;
      cont_r <= 1'b0;
      sleep_r <= 1'b0;
      cal_r <= 2'h0;
      cal_cnt_r <= 16'h0000;
      conv_cnt_r <= 16'h0000;
      rdy_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      regs_r <= regs_nxt;
      rx_r <= rx_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      addr_r <= addr_nxt;
      cnt_r <= cnt_nxt;
      is_wr_r <= is_wr_nxt;
      cont_r <= cont_nxt;
      sleep_r <= sleep_nxt;
      cal_r <= cal_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      rdy_n_r <= rdy_n_nxt;
    end
  end

  // Outputs
  assign link.dout     = (st_r == ST_TX) ? tx_r[7] : 1'b0;
  assign link.ready_n  = rdy_n_r;
  assign low_power_out = sleep_r;
  assign cal_busy_out  = (cal_r != 2'b00);
endmodule
`default_nettype wire

// ---- ascd_host.sv ----
/*
  Host end: sends one command byte plus optional count and data
  bytes, and collects reply bytes, MSB first.
  Assumes the device end of ascd_if on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ascd_host
  import ascd_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  // User request
  input  wire logic       req_valid_in,    // Start a byte transfer
  input  wire logic [7:0] req_byte_in,     // Byte to send
  input  wire logic       req_last_in,     // Release select after byte
  input  wire logic       wait_ready_in,   // Hold until ready low plus guard
  output logic            req_ready_out,   // Idle, may take request
  output logic            rsp_valid_out,   // One-cycle reply pulse
  output logic [7:0]      rsp_byte_out,    // Byte shifted in
  // Serial link
  ascd_if.host            link
);
  localparam int GUARD_CYCLES = OSC_WAIT_PERIODS;  // Ten clock periods

  typedef enum {HS_IDLE, HS_GUARD, HS_LOW, HS_HIGH} ascd_hstate_e;

  ascd_hstate_e st_r, st_nxt;          // Host state
  logic [7:0]   tx_r, tx_nxt;          // Outgoing shift
  logic [7:0]   rx_r, rx_nxt;          // Incoming shift
  logic [2:0]   bit_r, bit_nxt;        // Bit counter
  logic [3:0]   div_r, div_nxt;        // Serial clock divider / guard
  logic         last_r, last_nxt;      // Release select at end
  logic         cs_n_r, cs_n_nxt;      // Select level
  logic         rvalid_r, rvalid_nxt;  // Reply pulse

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    bit_nxt = bit_r;
    div_nxt = div_r;
    last_nxt = last_r;
    cs_n_nxt = cs_n_r;
    rvalid_nxt = 1'b0;
    case (st_r)
      HS_IDLE: begin
        if (req_valid_in) begin
          tx_nxt = req_byte_in;
          last_nxt = req_last_in;
          bit_nxt = '0;
          div_nxt = '0;
          st_nxt = wait_ready_in ? HS_GUARD : HS_LOW;
          cs_n_nxt = cs_n_r && wait_ready_in;  // Select drops as clocking starts
        end
      end
      HS_GUARD: begin
        // Wait for ready low, then ten periods
        if (link.ready_n) begin
          div_nxt = '0;
        end else if (div_r == 4'(GUARD_CYCLES - 1)) begin
          div_nxt = '0;
          cs_n_nxt = 1'b0;  // Select a full low phase before the first edge
          st_nxt = HS_LOW;
        end else begin
          div_nxt = div_r + 4'h1;
        end
      end
      HS_LOW: begin
        cs_n_nxt = 1'b0;
        div_nxt = div_r + 4'h1;
        if (div_r == 4'(SCLK_DIV - 1)) begin
          div_nxt = '0;
          st_nxt = HS_HIGH;
        end
      end
      HS_HIGH: begin
        div_nxt = div_r + 4'h1;
        if (div_r == 4'h0) begin
          rx_nxt = {rx_r[6:0], link.dout};  // Sample with the edge
        end
        if (div_r == 4'(SCLK_DIV - 1)) begin
          div_nxt = '0;
          tx_nxt = {tx_r[6:0], 1'b0};
          bit_nxt = bit_r + 3'd1;
          st_nxt = HS_LOW;
          if (bit_r == 3'd7) begin
            rvalid_nxt = 1'b1;
            st_nxt = HS_IDLE;
            cs_n_nxt = last_r;
          end
        end
      end
      default: st_nxt = HS_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_r <= HS_IDLE;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      bit_r <= 3'h0;
      div_r <= 4'h0;
      last_r <= 1'b1;
      cs_n_r <= 1'b1;
      rvalid_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      bit_r <= bit_nxt;
      div_r <= div_nxt;
      last_r <= last_nxt;
      cs_n_r <= cs_n_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Outputs
  assign link.cs_n      = cs_n_r;
  assign link.sclk      = (st_r == HS_HIGH);
  assign link.sclk_rise = (st_r == HS_HIGH) && (div_r == 4'h0);
  assign link.din       = tx_r[7];
  assign req_ready_out  = (st_r == HS_IDLE);
  assign rsp_valid_out  = rvalid_r;
  assign rsp_byte_out   = rx_r;
endmodule
`default_nettype wire

// ---- ascd_monitor.sv ----
/*
  Checker for the serial link between the host and device ends.
  Assumes it sits beside the link interface, on the one system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ascd_monitor
  import ascd_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  // Link signals
  input  wire logic sclk,
  input  wire logic sclk_rise,
  input  wire logic cs_n,
  input  wire logic din,
  input  wire logic dout,
  input  wire logic ready_n
);
  logic [7:0] sh_r;      // Host bits seen so far
  logic [7:0] sh_nxt;    // Next shift value
  logic [2:0] cnt_r;     // Bit position in byte
  logic [2:0] cnt_nxt;   // Next bit position
  logic       done;      // Byte completes now
  logic [7:0] byte_now;  // Byte value as completed

  // Rebuild host bytes, MSB first
  always_comb begin
    byte_now = {sh_r[6:0], din};
    done     = sclk_rise && !cs_n && (cnt_r == 3'h7);
    sh_nxt   = sh_r;
    cnt_nxt  = cnt_r;
    if (cs_n) begin
      // Deselect restarts the byte
      cnt_nxt = 3'h0;
    end else if (sclk_rise) begin
      sh_nxt  = byte_now;
      cnt_nxt = cnt_r + 3'h1;
    end
  end

  // Register the byte tracker
  always_ff @(posedge mclk_in) begin
    sh_r  <= sys_rst_in ? 8'h00 : sh_nxt;
    cnt_r <= sys_rst_in ? 3'h0 : cnt_nxt;
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  a_rise_on_edge: assert property (sclk_rise |-> sclk && !$past(sclk))
    else $error("sample pulse without a rising serial clock");
  a_rise_spacing: assert property (sclk_rise |=> !sclk_rise [*7])
    else $error("sample pulses closer than eight cycles");
  a_high_width: assert property ($rose(sclk) |-> sclk [*4])
    else $error("serial clock high phase too short");
  a_low_width: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  a_idle_no_clock: assert property (cs_n |-> !sclk_rise)
    else $error("sample pulse while deselected");
  a_cs_quiet: assert property ($fell(cs_n) |-> !sclk_rise [*4])
    else $error("clocking starts too soon after select");
  a_cal_ready_high: assert property (done && byte_now inside {[OP_CAL_FULL:OP_SYS_GAIN]}
    |-> ##[1:8] ready_n [*8])
    else $error("ready not held high during calibration");
  a_resync_ready: assert property (done && byte_now == OP_RESYNC |-> ##[1:8] ready_n)
    else $error("ready not cleared by resync");
endmodule
`default_nettype wire

// ---- adc_serial_command_decoder_test.sv ----
/*
  Testbench: host end drives device end over the link interface.
  Assumes the design package and both ends are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_serial_command_decoder_test
  import ascd_pkg::*;
;
  logic        mclk_in;        // System clock
  logic        sys_rst_in;     // Sync reset
  logic        req_valid_in;   // Host request
  logic [7:0]  req_byte_in;    // Byte to send
  logic        req_last_in;    // Deselect after byte
  logic        wait_ready_in;  // Wait for ready first
  logic        req_ready_out;  // Host idle
  logic        rsp_valid_out;  // Reply pulse
  logic [7:0]  rsp_byte_out;   // Reply byte
  logic [23:0] sample_in;      // Converter word
  logic [23:0] cal_offset_in;  // Offset coefficient
  logic [23:0] cal_gain_in;    // Gain coefficient
  logic        low_power_out;  // Sleep flag
  logic        cal_busy_out;   // Calibration flag
  int          n_fail;         // Mismatches
  int          n_checks;       // Comparisons
  int          cyc = 0;        // Cycle count
  int          i;              // Loop index
  int          k;              // Loop index
  logic [7:0]  rb;             // Last reply byte
  logic [7:0]  got [16];       // Register read data
  logic [47:0] coef_e;         // Expected gain and offset

  ascd_if link_if ();
  ascd_device #(.CONV_CYCLES(50), .CAL_CYCLES(20)) ascd_device_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link_if),
    .sample_in(sample_in), .cal_offset_in(cal_offset_in),
    .cal_gain_in(cal_gain_in), .low_power_out(low_power_out),
    .cal_busy_out(cal_busy_out));
  ascd_host ascd_host_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
    .req_byte_in(req_byte_in), .req_last_in(req_last_in),
    .wait_ready_in(wait_ready_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_byte_out(rsp_byte_out), .link(link_if));
  ascd_monitor ascd_monitor_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .sclk(link_if.sclk),
    .sclk_rise(link_if.sclk_rise), .cs_n(link_if.cs_n), .din(link_if.din),
    .dout(link_if.dout), .ready_n(link_if.ready_n));

  // Clock at 40 MHz
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Verdict and end of run
  task complete_run;
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Byte comparison
  task chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One byte through the host end
  task xfer(input logic [7:0] b, input logic last, input logic wr);
    int w;
    w = 0;
    req_valid_in  <= 1'b1;
    req_byte_in   <= b;
    req_last_in   <= last;
    wait_ready_in <= wr;
    @(posedge mclk_in);
    while (req_ready_out !== 1'b1 && w < 3000) begin
      @(posedge mclk_in);
      w++;
    end
    req_valid_in <= 1'b0;
    do begin
      @(posedge mclk_in);
      w++;
    end while (rsp_valid_out !== 1'b1 && w < 6000);
    rb = rsp_byte_out;
  endtask

  // Register read, count byte as given
  task register_read_cmd(input logic [3:0] a, input logic [7:0] cnt);
    int j;
    xfer({OP_REGISTER_READ_CMD_HI, a}, 1'b0, 1'b0);
    xfer(cnt, 1'b0, 1'b0);
    for (j = 0; j <= int'(cnt[3:0]); j++) begin
      xfer(8'h00, j == int'(cnt[3:0]), 1'b0);
      got[j] = rb;
    end
  endtask

  // Hang guard
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    n_fail = 0;
    n_checks = 0;
    sys_rst_in = 1'b1;
    req_valid_in = 1'b0;
    req_byte_in = 8'h00;
    req_last_in = 1'b0;
    wait_ready_in = 1'b0;
    sample_in = 24'hA5C3E1;
    cal_offset_in = 24'h000000;
    cal_gain_in = 24'h000000;
    coef_e = 48'h555559_000000;
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    // Power-up values, count high nibble ignored
    register_read_cmd(4'h0, 8'hEF);
    for (i = 0; i < 13; i++) begin
      chk8(got[i] & ((i == 2) ? 8'h7F : 8'hFF), REG_RESET_VAL[8*i+:8]);
    end
    // Single result read, MSB first
    xfer(OP_READ_RESULT, 1'b0, 1'b0);
    for (i = 0; i < 3; i++) begin
      xfer(8'h00, i == 2, 1'b0);
      chk8(rb, sample_in[23-8*i-:8]);
    end
    // Result registers, then wrap to zero
    register_read_cmd(4'hD, 8'h04);
    for (i = 0; i < 3; i++) chk8(got[i], sample_in[23-8*i-:8]);
    chk8(got[3], REG_RESET_VAL[7:0]);
    chk8(got[4], REG_RESET_VAL[15:8]);
    // Write two registers; result register refuses writes
    xfer({OP_REGISTER_WRITE_CMD_HI, 4'h3}, 1'b0, 1'b0);
    xfer(8'hA1, 1'b0, 1'b0);
    xfer(8'h3C, 1'b0, 1'b0);
    xfer(8'h6A, 1'b1, 1'b0);
    xfer({OP_REGISTER_WRITE_CMD_HI, 4'hD}, 1'b0, 1'b0);
    xfer(8'h00, 1'b0, 1'b0);
    xfer(8'h99, 1'b1, 1'b0);
    register_read_cmd(4'h3, 8'h01);
    chk8(got[0], 8'h3C);
    chk8(got[1], 8'h6A);
    register_read_cmd(4'hD, 8'h00);
    chk8(got[0], sample_in[23:16]);
    // Every calibration kind
    for (k = 0; k < 5; k++) begin
      cal_offset_in <= 24'h123400 + 24'(k);
      cal_gain_in   <= 24'h876500 + 24'(k);
      xfer(OP_CAL_FULL + 8'(k), 1'b1, 1'b0);
      chk8({7'h00, cal_busy_out}, 8'h01);
      chk8({7'h00, link_if.ready_n}, 8'h01);
      for (i = 0; i < 200 && cal_busy_out !== 1'b0; i++) @(posedge mclk_in);
      chk8({7'h00, cal_busy_out}, 8'h00);
      chk8({7'h00, link_if.ready_n}, 8'h00);
      if (k != 2 && k != 4) coef_e[23:0] = 24'h123400 + 24'(k);
      if (k == 0 || k == 2 || k == 4) coef_e[47:24] = 24'h876500 + 24'(k);
      register_read_cmd(4'h7, 8'h05);
      for (i = 0; i < 6; i++) chk8(got[i], coef_e[8*i+:8]);
    end
    // Sleep ignores all but wake
    xfer(OP_SLEEP, 1'b1, 1'b0);
    xfer(OP_RESET, 1'b1, 1'b0);
    chk8({7'h00, low_power_out}, 8'h01);
    xfer(OP_WAKE, 1'b1, 1'b0);
    xfer(8'h77, 1'b1, 1'b0);
    chk8({7'h00, low_power_out}, 8'h00);
    // Status byte: result pending, so ready bit low
    register_read_cmd(4'h2, 8'h01);
    chk8(got[0], 8'h00);
    chk8(got[1], 8'h3C);
    // Resync, then continuous read ended by stop byte
    xfer(OP_RESYNC, 1'b1, 1'b0);
    xfer(OP_READ_CONT, 1'b1, 1'b0);
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 3; i++) begin
        xfer((k == 1 && i == 0) ? OP_STOP_CONT : 8'h00, i == 2, i == 0);
        chk8(rb, sample_in[23-8*i-:8]);
      end
    end
    register_read_cmd(4'h0, 8'h00);
    chk8(got[0], REG_RESET_VAL[7:0]);
    // Reset opcode restores written registers
    xfer(OP_RESET, 1'b1, 1'b0);
    register_read_cmd(4'h3, 8'h01);
    chk8(got[0], REG_RESET_VAL[31:24]);
    chk8(got[1], REG_RESET_VAL[39:32]);
    // Reset byte during continuous readout ends the mode
    xfer(OP_READ_CONT, 1'b1, 1'b0);
    for (i = 0; i < 3; i++) begin
      xfer((i == 0) ? OP_RESET : 8'h00, i == 2, i == 0);
      chk8(rb, sample_in[23-8*i-:8]);
    end
    register_read_cmd(4'h0, 8'h00);
    chk8(got[0], REG_RESET_VAL[7:0]);
    complete_run();
  end
endmodule
`default_nettype wire
